/* src/fp_port_regs.svh */
`ifndef FP_PORT_REGS_SVH
`define FP_PORT_REGS_SVH

// --------------------------------------------------------------------
// commit_select codes
// --------------------------------------------------------------------
`define COMMIT_HOLD      2'h0
`define COMMIT_OPERAND   2'h1
`define COMMIT_MODE      2'h2
`define COMMIT_SPARE     2'h3

// --------------------------------------------------------------------
// drain_select codes
// --------------------------------------------------------------------
`define DRAIN_OFF        2'h0
`define DRAIN_UPPER      2'h1
`define DRAIN_LOWER      2'h2
`define DRAIN_KEEP       2'h3

// --------------------------------------------------------------------
// operation_select codes
// --------------------------------------------------------------------
`define OP_MUL           4'h0
`define OP_PASS_A        4'h1
`define OP_PASS_B        4'h2
`define OP_ABS_A         4'h3
`define OP_NEG_A         4'h4

// --------------------------------------------------------------------
// exception_flags_out encodings
// --------------------------------------------------------------------
`define EXC_NONE         3'h0
`define EXC_INEXACT      3'h1
`define EXC_UNDERFLOW    3'h2
`define EXC_OVERFLOW     3'h3
`define EXC_INVALID      3'h4
`define EXC_DENORM       3'h5

// --------------------------------------------------------------------
// event bit positions in status and mask registers
// --------------------------------------------------------------------
`define EV_INEXACT       0
`define EV_UNDERFLOW     1
`define EV_OVERFLOW      2
`define EV_INVALID       3
`define EV_DENORM        4
`define EV_WIDTH         5

// --------------------------------------------------------------------
// register offsets and reset values
// --------------------------------------------------------------------
`define REG_STATUS       8'h00
`define REG_MASK         8'h04
`define REG_MODE         8'h08
`define REG_RESULT       8'h0C
`define MODE_FAST_BIT    4
`define MODE_RST         5'h00
`define MASK_RST         5'h00

// --------------------------------------------------------------------
// floating point constants
// --------------------------------------------------------------------
`define EXP_BIAS         10'h07F
`define EXP_OVF          10'h17E
`define EXP_ALL_ONES     8'hFF
`define QUIET_NAN        32'h7FC00000

`endif

/* src/fp_port_pkg.sv */
package fp_port_pkg;

    // single precision word: sign on top, biased exponent, fraction low
    typedef struct packed {
        logic        sign;
        logic [7:0]  expo;
        logic [22:0] frac;
    } fp_word_t;

    typedef struct packed {
        logic zero;
        logic denorm;
        logic inf;
        logic nan;
    } fp_class_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LOWER = 2'b01,
        ST_EXEC  = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        seq_state_t  seq;
        logic [15:0] a_hi;
        logic [15:0] b_hi;
        fp_word_t    a_op;
        fp_word_t    b_op;
        logic [3:0]  func_pend;
        logic [3:0]  func_exec;
        logic [4:0]  mode;
        fp_word_t    result;
        logic [2:0]  exc;
        logic [15:0] out;
        logic        oe;
        logic [4:0]  status;
        logic [4:0]  mask;
        logic        irq;
        logic [31:0] rdata;
    } core_state_t;

endpackage

/* src/fp_classify.sv */
`timescale 1ns/10ps
`include "fp_port_regs.svh"

// --------------------------------------------------------------------
// operand classifier, one per operand
// --------------------------------------------------------------------
module fp_classify
    import fp_port_pkg::*;
(
    input  wire fp_word_t  word,
    output fp_class_t      cls
);

    logic exp_zero;
    logic exp_full;
    logic frac_zero;

    // exponent extremes select the special classes
    always_comb begin
        exp_zero   = (word.expo == '0);
        exp_full   = (word.expo == `EXP_ALL_ONES);
        frac_zero  = (word.frac == '0);
        cls.zero   = exp_zero & frac_zero;   // either sign
        cls.denorm = exp_zero & ~frac_zero;
        cls.inf    = exp_full & frac_zero;
        cls.nan    = exp_full & ~frac_zero;
    end

endmodule

/* src/fp_unit_host_port.sv */
`timescale 1ns/10ps
`include "fp_port_regs.svh"

// Overview of operation
// - upper half on commit edge, lower next edge
// - result leaves as selected sixteen-bit half
// - all registers update on rising clock edge
// - commit field moves inputs and loads mode
// - drain field enables or floats result drivers
// - one drain bit joins mode register value
// - operation field selects op or mode contents
// - three-bit flags report exceptions and denormals
// - words are sign, exponent, fraction
// - sign one negative, zero accepted either sign
// - upper half holds sign, exponent, top fraction
module fp_unit_host_port
    import fp_port_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic [15:0] OPERAND_FIRST_IN_BUS,
    input  wire logic [15:0] OPERAND_SECOND_IN_BUS,
    input  wire logic [1:0]  COMMIT_SELECT,
    input  wire logic [1:0]  DRAIN_SELECT,
    input  wire logic [3:0]  OPERATION_SELECT,
    output logic      [15:0] RESULT_OUT_BUS_O,
    output logic             RESULT_OUT_BUS_OE,
    output logic      [2:0]  EXCEPTION_FLAGS_OUT,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    output logic             IRQ
);

    // ----------------------------------------------------------------
    // state and helpers
    // ----------------------------------------------------------------
    core_state_t state_ff;
    core_state_t nxt_state;
    reg_req_t    req;
    fp_class_t   cls_a;
    fp_class_t   cls_b;

    // bus signals travel together
    assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

    // ----------------------------------------------------------------
    // operand classification
    // ----------------------------------------------------------------
    fp_classify u_class_a (
        .word (state_ff.a_op),
        .cls  (cls_a)
    );

    fp_classify u_class_b (
        .word (state_ff.b_op),
        .cls  (cls_b)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    // working values for the arithmetic; all given a value up front
    logic [23:0]        sig_a;
    logic [23:0]        sig_b;
    logic [47:0]        product;
    logic [9:0]         e_sum;
    logic [9:0]         e_adj;
    logic [22:0]        mant;
    logic               lost;
    logic               a_flush;
    logic               b_flush;
    logic               sgn;
    logic               fast;
    fp_word_t           res;
    logic [`EV_WIDTH-1:0] ev;
    logic [`EV_WIDTH-1:0] clr;
    logic [2:0]         exc_code;
    logic               mode_load;

    always_comb begin
        nxt_state = state_ff;
        sig_a     = '0;
        sig_b     = '0;
        product   = '0;
        e_sum     = '0;
        e_adj     = '0;
        mant      = '0;
        lost      = 1'b0;
        res       = state_ff.result;
        ev        = '0;
        clr       = '0;
        exc_code  = `EXC_NONE;
        mode_load = 1'b0;
        fast      = state_ff.mode[`MODE_FAST_BIT];
        // denormals are flushed to zero; only the flag differs by mode
        a_flush   = cls_a.zero | cls_a.denorm;
        b_flush   = cls_b.zero | cls_b.denorm;
        sgn       = state_ff.a_op.sign ^ state_ff.b_op.sign;

        // ------------------------------------------------------------
        // multiplier datapath, hidden bit inserted from the class
        // ------------------------------------------------------------
        sig_a   = {~a_flush, state_ff.a_op.frac};
        sig_b   = {~b_flush, state_ff.b_op.frac};
        product = sig_a * sig_b;
        e_sum   = {2'h0, state_ff.a_op.expo} + {2'h0, state_ff.b_op.expo} + {9'h000, product[47]};
        e_adj   = e_sum - `EXP_BIAS;
        // normalise by at most one place; truncation drops the rest
        if (product[47]) begin
            mant = product[46:24];
            lost = |product[23:0];
        end else begin
            mant = product[45:23];
            lost = |product[22:0];
        end

        // ------------------------------------------------------------
        // capture sequence: upper halves, then lower halves, then run
        // ------------------------------------------------------------
        unique case (state_ff.seq)
            ST_IDLE, ST_EXEC: begin
                if (COMMIT_SELECT == `COMMIT_OPERAND) begin
                    nxt_state.a_hi      = OPERAND_FIRST_IN_BUS;
                    nxt_state.b_hi      = OPERAND_SECOND_IN_BUS;
                    nxt_state.func_pend = OPERATION_SELECT;
                    nxt_state.seq       = ST_LOWER;
                end else begin
                    nxt_state.seq = ST_IDLE;
                end
                if (COMMIT_SELECT == `COMMIT_MODE) begin
                    // drain bit rides along as the fast-mode bit
                    nxt_state.mode = {DRAIN_SELECT[0], OPERATION_SELECT};
                    mode_load      = 1'b1;
                end
            end
            ST_LOWER: begin
                // commit field is ignored here: this edge owns the buses
                nxt_state.a_op      = {state_ff.a_hi, OPERAND_FIRST_IN_BUS};
                nxt_state.b_op      = {state_ff.b_hi, OPERAND_SECOND_IN_BUS};
                nxt_state.func_exec = state_ff.func_pend;
                nxt_state.seq       = ST_EXEC;
            end
            default: begin
                nxt_state.seq = ST_IDLE;
            end
        endcase

        // ------------------------------------------------------------
        // execute stage: one result per two captures
        // ------------------------------------------------------------
        if (state_ff.seq == ST_EXEC) begin
            unique case (state_ff.func_exec)
                `OP_MUL: begin
                    if (cls_a.nan | cls_b.nan | (cls_a.inf & b_flush) | (cls_b.inf & a_flush)) begin
                        res                 = `QUIET_NAN;
                        ev[`EV_INVALID]     = 1'b1;
                    end else if (cls_a.inf | cls_b.inf) begin
                        res = {sgn, `EXP_ALL_ONES, 23'h000000};
                    end else if (a_flush | b_flush) begin
                        res = {sgn, 31'h00000000};
                    end else if (e_sum >= `EXP_OVF) begin
                        res                 = {sgn, `EXP_ALL_ONES, 23'h000000};
                        ev[`EV_OVERFLOW]    = 1'b1;
                        ev[`EV_INEXACT]     = 1'b1;
                    end else if (e_sum <= `EXP_BIAS) begin
                        res                 = {sgn, 31'h00000000};
                        ev[`EV_UNDERFLOW]   = 1'b1;
                        ev[`EV_INEXACT]     = 1'b1;
                    end else begin
                        res                 = {sgn, e_adj[7:0], mant};
                        ev[`EV_INEXACT]     = lost;
                    end
                    // fast mode substitutes zero silently
                    ev[`EV_DENORM] = (cls_a.denorm | cls_b.denorm) & ~fast;
                end
                `OP_PASS_A: begin
                    res = state_ff.a_op;
                end
                `OP_PASS_B: begin
                    res = state_ff.b_op;
                end
                `OP_ABS_A: begin
                    res      = state_ff.a_op;
                    res.sign = 1'b0;
                end
                `OP_NEG_A: begin
                    res      = state_ff.a_op;
                    res.sign = ~state_ff.a_op.sign;
                end
                default: begin
                    // unsupported operation code
                    res             = `QUIET_NAN;
                    ev[`EV_INVALID] = 1'b1;
                end
            endcase

            // one code on the pins, most serious event wins
            if (ev[`EV_INVALID]) begin
                exc_code = `EXC_INVALID;
            end else if (ev[`EV_DENORM]) begin
                exc_code = `EXC_DENORM;
            end else if (ev[`EV_OVERFLOW]) begin
                exc_code = `EXC_OVERFLOW;
            end else if (ev[`EV_UNDERFLOW]) begin
                exc_code = `EXC_UNDERFLOW;
            end else if (ev[`EV_INEXACT]) begin
                exc_code = `EXC_INEXACT;
            end
            nxt_state.result = res;
            nxt_state.exc    = exc_code;
        end

        // ------------------------------------------------------------
        // output register and drivers
        // ------------------------------------------------------------
        // during a mode load the drain field carries mode data instead
        if (!mode_load) begin
            unique case (DRAIN_SELECT)
                `DRAIN_OFF: begin
                    nxt_state.oe = 1'b0;
                end
                `DRAIN_UPPER: begin
                    nxt_state.out = state_ff.result[31:16];
                    nxt_state.oe  = 1'b1;
                end
                `DRAIN_LOWER: begin
                    nxt_state.out = state_ff.result[15:0];
                    nxt_state.oe  = 1'b1;
                end
                `DRAIN_KEEP: begin
                    nxt_state.oe = 1'b1;
                end
            endcase
        end

        // ------------------------------------------------------------
        // register port: writes, sticky events, read data
        // ------------------------------------------------------------
        if (req.wr && req.addr == `REG_STATUS) begin
            clr = req.wdata[`EV_WIDTH-1:0];
        end
        if (req.wr && req.addr == `REG_MASK) begin
            nxt_state.mask = req.wdata[`EV_WIDTH-1:0];
        end
        // a new event beats a clear in the same cycle
        nxt_state.status = (state_ff.status & ~clr) | ev;
        nxt_state.irq    = |(nxt_state.status & nxt_state.mask);

        nxt_state.rdata = '0;
        if (req.rd) begin
            unique case (req.addr)
                `REG_STATUS: nxt_state.rdata = {27'h0000000, state_ff.status};
                `REG_MASK:   nxt_state.rdata = {27'h0000000, state_ff.mask};
                `REG_MODE:   nxt_state.rdata = {27'h0000000, state_ff.mode};
                `REG_RESULT: nxt_state.rdata = state_ff.result;
                default:     nxt_state.rdata = '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // every register advances on the rising edge only
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_ff           <= '0;
            state_ff.seq       <= ST_IDLE;
            state_ff.mode      <= `MODE_RST;
            state_ff.mask      <= `MASK_RST;
            state_ff.exc       <= `EXC_NONE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // outputs straight from flops
    // ----------------------------------------------------------------
    assign RESULT_OUT_BUS_O    = state_ff.out;
    assign RESULT_OUT_BUS_OE   = state_ff.oe;
    assign EXCEPTION_FLAGS_OUT = state_ff.exc;
    assign REG_RDATA           = state_ff.rdata;
    assign IRQ                 = state_ff.irq;

endmodule

/* sim/fp_port_props.sv */
`timescale 1ns/10ps
`include "fp_port_regs.svh"

// ------------------------------------------------------------
// port checker for the floating point host port
// ------------------------------------------------------------
module fp_port_props
    import fp_port_pkg::*;
(
    input wire logic        CLK,
    input wire logic        SRST,
    input wire logic [15:0] OPERAND_FIRST_IN_BUS,
    input wire logic [15:0] OPERAND_SECOND_IN_BUS,
    input wire logic [1:0]  COMMIT_SELECT,
    input wire logic [1:0]  DRAIN_SELECT,
    input wire logic [3:0]  OPERATION_SELECT,
    input wire logic [15:0] RESULT_OUT_BUS_O,
    input wire logic        RESULT_OUT_BUS_OE,
    input wire logic [2:0]  EXCEPTION_FLAGS_OUT,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic        IRQ
);
    logic lower_ff;
    logic exec_ff;
    logic mode_ld;

    // shadow of the sequencer: a commit in the lower-half cycle is ignored
    always_ff @(posedge CLK) begin
        if (SRST) begin
            lower_ff <= 1'b0;
            exec_ff  <= 1'b0;
        end else begin
            lower_ff <= (COMMIT_SELECT == `COMMIT_OPERAND) && !lower_ff;
            exec_ff  <= lower_ff;
        end
    end
    assign mode_ld = (COMMIT_SELECT == `COMMIT_MODE) && !lower_ff;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    drain_off_a: assert property ((DRAIN_SELECT == `DRAIN_OFF) && !mode_ld |=> !RESULT_OUT_BUS_OE)
        else $error("result drivers on after drain off");
    drain_on_a: assert property ((DRAIN_SELECT != `DRAIN_OFF) && !mode_ld |=> RESULT_OUT_BUS_OE)
        else $error("result drivers off after drain select");
    mode_hold_a: assert property (mode_ld |=> $stable(RESULT_OUT_BUS_OE) && $stable(RESULT_OUT_BUS_O))
        else $error("output changed during mode load");
    drain_keep_a: assert property ((DRAIN_SELECT == `DRAIN_KEEP) && !mode_ld |=> $stable(RESULT_OUT_BUS_O))
        else $error("output changed on keep code");
    upper_half_a: assert property (REG_RD && REG_ADDR == `REG_RESULT && DRAIN_SELECT == `DRAIN_UPPER
        && !mode_ld |=> RESULT_OUT_BUS_O == REG_RDATA[31:16])
        else $error("upper half differs from result");
    lower_half_a: assert property (REG_RD && REG_ADDR == `REG_RESULT && DRAIN_SELECT == `DRAIN_LOWER
        && !mode_ld |=> RESULT_OUT_BUS_O == REG_RDATA[15:0])
        else $error("lower half differs from result");
    flags_time_a: assert property (!$stable(EXCEPTION_FLAGS_OUT) |-> $past(exec_ff))
        else $error("flags changed outside execute");
    irq_masked_a: assert property (REG_WR && REG_ADDR == `REG_MASK && REG_WDATA[4:0] == 5'h00 |=> !IRQ)
        else $error("interrupt high with all masked");
    rdata_idle_a: assert property (!REG_RD |=> REG_RDATA == 32'h00000000)
        else $error("read data not zero when idle");
    unmapped_a: assert property (REG_RD && !(REG_ADDR inside {`REG_STATUS, `REG_MASK, `REG_MODE, `REG_RESULT})
        |=> REG_RDATA == 32'h00000000)
        else $error("unmapped read not zero");
endmodule

bind fp_unit_host_port fp_port_props i_props (.CLK(CLK), .SRST(SRST),
    .OPERAND_FIRST_IN_BUS(OPERAND_FIRST_IN_BUS), .OPERAND_SECOND_IN_BUS(OPERAND_SECOND_IN_BUS),
    .COMMIT_SELECT(COMMIT_SELECT), .DRAIN_SELECT(DRAIN_SELECT), .OPERATION_SELECT(OPERATION_SELECT),
    .RESULT_OUT_BUS_O(RESULT_OUT_BUS_O), .RESULT_OUT_BUS_OE(RESULT_OUT_BUS_OE),
    .EXCEPTION_FLAGS_OUT(EXCEPTION_FLAGS_OUT), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));

/* sim/fp_host_model.sv */
`timescale 1ns/10ps
`include "fp_port_regs.svh"

// ------------------------------------------------------------
// host controller driving the operand buses
// ------------------------------------------------------------
module fp_host_model
    import fp_port_pkg::*;
(
    input wire logic        clk,
    input wire logic        go,
    input wire logic [1:0]  code,
    input wire fp_word_t    a_w,
    input wire fp_word_t    b_w,
    input wire logic [3:0]  op,
    output logic     [15:0] bus_a,
    output logic     [15:0] bus_b,
    output logic     [1:0]  commit,
    output logic     [3:0]  func
);
    logic lower;

    initial begin
        bus_a  = 16'h0000;
        bus_b  = 16'h0000;
        commit = `COMMIT_HOLD;
        func   = 4'h0;
        lower  = 1'b0;
    end

    // upper halves with the commit code, lower halves on the next edge
    always @(posedge clk) begin
        if (go) begin
            commit <= code;
            func   <= op;
            bus_a  <= a_w[31:16];
            bus_b  <= b_w[31:16];
            lower  <= (code == `COMMIT_OPERAND);
        end else if (lower) begin
            commit <= `COMMIT_HOLD;
            bus_a  <= a_w[15:0];
            bus_b  <= b_w[15:0];
            lower  <= 1'b0;
        end else begin
            // idle buses carry junk so a late capture cannot look right
            commit <= `COMMIT_HOLD;
            bus_a  <= ~bus_a;
            bus_b  <= ~bus_b;
            func   <= ~func;
        end
    end
endmodule

/* sim/test_fp_unit_host_port.sv */
`timescale 1ns/10ps
`include "fp_port_regs.svh"

`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module test_fp_unit_host_port
    import fp_port_pkg::*;
;
    logic        clk;
    logic        srst;
    logic        go;
    logic        reg_wr;
    logic        reg_rd;
    logic [1:0]  drain;
    logic [1:0]  code;
    logic [3:0]  op;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    fp_word_t    a_w;
    fp_word_t    b_w;
    wire  [15:0] bus_a;
    wire  [15:0] bus_b;
    wire  [15:0] res_o;
    wire  [1:0]  commit;
    wire  [3:0]  func;
    wire         res_oe;
    wire         irq;
    wire  [2:0]  flags;
    wire  [31:0] reg_rdata;
    wire  [15:0] res_wire = res_oe ? res_o : 16'hZZZZ;
    int          err_count;
    int          checks_done;
    // operand, operation and expected result table
    logic [31:0] t_a [11] = '{32'hC0490FDB, 32'h40000000, 32'h00000000, 32'h80000000, 32'h00000000,
        32'h7F000000, 32'h00800000, 32'h3F800001, 32'h7F800000, 32'h00000001, 32'h3F800000};
    logic [31:0] t_b [11] = '{32'h00000000, 32'h40400000, 32'h3F800000, 32'h00000000, 32'h41200000,
        32'h7F000000, 32'h00800000, 32'h3F800001, 32'h00000000, 32'h40000000, 32'h00000000};
    logic [3:0]  t_op [11] = '{`OP_PASS_A, `OP_MUL, `OP_NEG_A, `OP_ABS_A, `OP_PASS_B,
        `OP_MUL, `OP_MUL, `OP_MUL, `OP_MUL, `OP_MUL, 4'hF};
    logic [31:0] t_r [11] = '{32'hC0490FDB, 32'h40C00000, 32'h80000000, 32'h00000000, 32'h41200000,
        32'h7F800000, 32'h00000000, 32'h3F800002, `QUIET_NAN, 32'h00000000, `QUIET_NAN};
    logic [2:0]  t_f [11] = '{`EXC_NONE, `EXC_NONE, `EXC_NONE, `EXC_NONE, `EXC_NONE,
        `EXC_OVERFLOW, `EXC_UNDERFLOW, `EXC_INEXACT, `EXC_INVALID, `EXC_DENORM, `EXC_INVALID};

    fp_unit_host_port i_dut (.CLK(clk), .SRST(srst), .OPERAND_FIRST_IN_BUS(bus_a),
        .OPERAND_SECOND_IN_BUS(bus_b), .COMMIT_SELECT(commit), .DRAIN_SELECT(drain),
        .OPERATION_SELECT(func), .RESULT_OUT_BUS_O(res_o), .RESULT_OUT_BUS_OE(res_oe),
        .EXCEPTION_FLAGS_OUT(flags), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IRQ(irq));

    fp_host_model i_host (.clk(clk), .go(go), .code(code), .a_w(a_w), .b_w(b_w), .op(op),
        .bus_a(bus_a), .bus_b(bus_b), .commit(commit), .func(func));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------
    // register port and operand tasks
    // ------------------------------------------------------------
    task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] addr, input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        `CHECK(reg_rdata, exp)
    endtask

    // mode data rides on the drain field in the cycle the commit is seen
    task automatic run_op(input logic [1:0] c, input logic [31:0] a, input logic [31:0] b,
                          input logic [3:0] f, input logic [1:0] md);
        @(posedge clk);
        go  <= 1'b1;
        code <= c;
        a_w <= a;
        b_w <= b;
        op  <= f;
        @(posedge clk);
        go  <= 1'b0;
        if (c == `COMMIT_MODE) drain <= md;
        repeat (3) @(posedge clk);
    endtask

    // drain and a result read in the same cycle see the same result
    task automatic drain_chk(input logic [1:0] c, input logic [31:0] exp_r);
        @(posedge clk);
        drain    <= c;
        reg_rd   <= 1'b1;
        reg_addr <= `REG_RESULT;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        `CHECK(reg_rdata, exp_r)
        `CHECK(res_wire, c == `DRAIN_OFF ? 16'hZZZZ : c == `DRAIN_UPPER ? exp_r[31:16] : exp_r[15:0])
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        go = 1'b0;
        code = `COMMIT_HOLD;
        op = 4'h0;
        a_w = 32'h00000000;
        b_w = 32'h00000000;
        drain = `DRAIN_OFF;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        #1;
        `CHECK({res_oe, irq, flags}, 5'h00)
        reg_read(`REG_MODE, 32'h00000000);
        reg_read(`REG_MASK, 32'h00000000);
        reg_read(`REG_STATUS, 32'h00000000);
        reg_read(8'h10, 32'h00000000);
        $display("reset test done");
        for (int i = 0; i < 11; i++) begin
            run_op(`COMMIT_OPERAND, t_a[i], t_b[i], t_op[i], drain);
            drain_chk(i[0] ? `DRAIN_UPPER : `DRAIN_LOWER, t_r[i]);
            `CHECK(flags, t_f[i])
        end
        drain_chk(`DRAIN_OFF, t_r[10]);
        $display("operation test done");
        run_op(`COMMIT_MODE, 32'h00000000, 32'h00000000, 4'hA, `DRAIN_KEEP);
        reg_read(`REG_MODE, 32'h0000001A);
        run_op(`COMMIT_OPERAND, 32'h00000001, 32'h40000000, `OP_MUL, drain);
        drain_chk(`DRAIN_LOWER, 32'h00000000);
        `CHECK(flags, `EXC_NONE)
        run_op(`COMMIT_SPARE, 32'h3F800000, 32'h3F800000, `OP_PASS_A, drain);
        drain_chk(`DRAIN_UPPER, 32'h00000000);
        $display("mode test done");
        reg_read(`REG_STATUS, 32'h0000001F);
        reg_write(`REG_MASK, 32'h00000008);
        #1;
        `CHECK(irq, 1'b1)
        reg_write(`REG_STATUS, 32'h00000008);
        #1;
        `CHECK(irq, 1'b0)
        reg_read(`REG_STATUS, 32'h00000017);
        reg_read(`REG_MASK, 32'h00000008);
        reg_write(`REG_MASK, 32'h00000000);
        reg_write(`REG_STATUS, 32'h0000001F);
        reg_read(`REG_STATUS, 32'h00000000);
        $display("interrupt test done");
        test_done;
    end

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk);
        err_count++;
        $display("watchdog expired");
        test_done;
    end
endmodule
